// *** hdl/fss_status_regs.sv ***
`include "fss_cfg.svh"
`default_nettype none
module fss_status_regs #(
  parameter int NPAGE = 2,
  parameter int PW    = 1
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // paged fault events, one-cycle pulses
  input  wire logic [NPAGE-1:0] vout_ov_evt,
  input  wire logic [NPAGE-1:0] vout_uv_evt,
  input  wire logic [NPAGE-1:0] iout_oc_evt,
  input  wire logic [NPAGE-1:0] temp_evt,
  input  wire logic [NPAGE-1:0] busy_evt,
  // global fault events, one-cycle pulses
  input  wire logic             vin_uv_evt,
  input  wire logic             vin_oth_evt,
  input  wire logic             cml_evt,
  input  wire logic             mfr_evt,
  // live per-page levels
  input  wire logic [NPAGE-1:0] pg_n,
  input  wire logic [NPAGE-1:0] out_off,
  // clear of latched faults: page flags per page, global flags on any bit
  input  wire logic [NPAGE-1:0] fault_clr,
  // command read port
  input  wire logic             rd_req,
  input  wire logic [7:0]       rd_cmd,
  input  wire logic [PW-1:0]    rd_page,
  output logic [15:0]           rd_data_q,
  output logic                  rd_ack_q,
  output logic                  rd_err_q
);

  // ****************************************
  // latched fault flags
  // ****************************************
  logic [NPAGE-1:0] ov_q, ov_d, uv_q, uv_d, oc_q, oc_d;
  logic [NPAGE-1:0] tmp_q, tmp_d, bsy_q, bsy_d;
  logic             vuv_q, vuv_d, voth_q, voth_d;
  logic             cml_q, cml_d, mfr_q, mfr_d;
  logic             gclr;

  // set wins over clear so an event in the clear cycle survives
  always_comb begin
    gclr   = |fault_clr;
    ov_d   = (ov_q & ~fault_clr) | vout_ov_evt;
    uv_d   = (uv_q & ~fault_clr) | vout_uv_evt;
    oc_d   = (oc_q & ~fault_clr) | iout_oc_evt;
    tmp_d  = (tmp_q & ~fault_clr) | temp_evt;
    bsy_d  = (bsy_q & ~fault_clr) | busy_evt;
    vuv_d  = (vuv_q & ~gclr) | vin_uv_evt;
    voth_d = (voth_q & ~gclr) | vin_oth_evt;
    cml_d  = (cml_q & ~gclr) | cml_evt;
    mfr_d  = (mfr_q & ~gclr) | mfr_evt;
  end

  // flags reset clear so all nine flag registers start at zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ov_q   <= '0;
      uv_q   <= '0;
      oc_q   <= '0;
      tmp_q  <= '0;
      bsy_q  <= '0;
      vuv_q  <= 1'b0;
      voth_q <= 1'b0;
      cml_q  <= 1'b0;
      mfr_q  <= 1'b0;
    end else begin
      ov_q   <= ov_d;
      uv_q   <= uv_d;
      oc_q   <= oc_d;
      tmp_q  <= tmp_d;
      bsy_q  <= bsy_d;
      vuv_q  <= vuv_d;
      voth_q <= voth_d;
      cml_q  <= cml_d;
      mfr_q  <= mfr_d;
    end
  end

  // ****************************************
  // per-page register images
  // ****************************************
  fss_pkg::fss_word_type sum_w  [NPAGE];
  fss_pkg::fss_byte_type vout_st[NPAGE];
  logic                  in_any;

  // images are built from flags, never stored twice, so the byte
  // and the low half of the word cannot drift apart
  always_comb begin
    in_any = vuv_q | voth_q;
    for (int p = 0; p < NPAGE; p++) begin
      vout_st[p]                = `FSS_VOUT_RST;
      vout_st[p][`FSS_V_OV]     = ov_q[p];
      vout_st[p][`FSS_V_UV]     = uv_q[p];
      sum_w[p]                  = `FSS_SUM_RST;
      sum_w[p][`FSS_W_VOUT]     = |vout_st[p];
      sum_w[p][`FSS_W_IOUT]     = oc_q[p];
      sum_w[p][`FSS_W_INPUT]    = in_any;
      sum_w[p][`FSS_W_MFR]      = mfr_q;
      sum_w[p][`FSS_W_PG_N]     = pg_n[p];
      sum_w[p][`FSS_W_OTHER]    = (|vout_st[p]) | oc_q[p] | in_any
                                  | tmp_q[p] | cml_q | mfr_q;
      sum_w[p][`FSS_W_BUSY]     = bsy_q[p];
      sum_w[p][`FSS_W_OFF]      = out_off[p];
      sum_w[p][`FSS_W_OV]       = ov_q[p];
      sum_w[p][`FSS_W_OC]       = oc_q[p];
      sum_w[p][`FSS_W_VIN_UV]   = vuv_q;
      sum_w[p][`FSS_W_TEMP]     = tmp_q[p];
      sum_w[p][`FSS_W_CML]      = cml_q;
      // faults that bits 7:1 do not name; upper byte shows source
      sum_w[p][`FSS_W_NOTA]     = uv_q[p] | voth_q | mfr_q;
    end
  end

  // ****************************************
  // command read port
  // ****************************************
  logic                  pg_ok;
  fss_pkg::fss_word_type sel_w;
  fss_pkg::fss_byte_type sel_v;
  logic [15:0]           rd_data_d;
  logic                  rd_ack_d, rd_err_d;

  // out-of-range page or unknown code answers zero with error,
  // since there is no write path nothing else can go wrong
  always_comb begin
    pg_ok     = 32'(rd_page) < NPAGE;
    sel_w     = pg_ok ? sum_w[rd_page] : `FSS_SUM_RST;
    sel_v     = pg_ok ? vout_st[rd_page] : `FSS_VOUT_RST;
    rd_data_d = 16'h0000;
    rd_ack_d  = rd_req;
    rd_err_d  = rd_req & ~pg_ok;
    if (rd_req && pg_ok) begin
      unique case (rd_cmd)
        `FSS_CMD_SUM_BYTE:  rd_data_d = {8'h00, sel_w[7:0]};
        `FSS_CMD_SUM_WORD:  rd_data_d = sel_w;
        `FSS_CMD_VOUT_STAT: rd_data_d = {8'h00, sel_v};
        default:            rd_err_d  = 1'b1;
      endcase
    end
  end

  // answer one edge after the request
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_q <= 16'h0000;
      rd_ack_q  <= 1'b0;
      rd_err_q  <= 1'b0;
    end else begin
      rd_data_q <= rd_data_d;
      rd_ack_q  <= rd_ack_d;
      rd_err_q  <= rd_err_d;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_word_read;
    rd_req && pg_ok && rd_cmd == `FSS_CMD_SUM_WORD |=> rd_ack_q && rd_data_q == $past(sel_w);
  endproperty
  a_word_read: assert property (p_word_read) else $error("word read mismatch");

  property p_byte_low;
    rd_req && pg_ok && rd_cmd == `FSS_CMD_SUM_BYTE
      |=> rd_data_q == {8'h00, $past(sel_w[7:0])};
  endproperty
  a_byte_low: assert property (p_byte_low) else $error("byte not low half");

  // ****************************************
  // read port contract
  // ****************************************
  property p_ack_req;
    rd_req |=> rd_ack_q;
  endproperty
  a_ack_req: assert property (p_ack_req) else $error("request not answered");

  property p_idle_zero;
    !rd_req |=> !rd_ack_q && !rd_err_q && rd_data_q == `FSS_SUM_RST;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("answer without request");

  property p_err_ack;
    rd_err_q |-> rd_ack_q && rd_data_q == `FSS_SUM_RST;
  endproperty
  a_err_ack: assert property (p_err_ack) else $error("error without ack");

  property p_vout_read;
    rd_req && pg_ok && rd_cmd == `FSS_CMD_VOUT_STAT
      |=> rd_data_q[15:8] == 8'h00 && rd_data_q[`FSS_V_OV] == $past(ov_q[rd_page])
      && rd_data_q[`FSS_V_UV] == $past(uv_q[rd_page]);
  endproperty
  a_vout_read: assert property (p_vout_read) else $error("vout status read wrong");

  property p_live_read;
    rd_req && pg_ok && rd_cmd == `FSS_CMD_SUM_WORD
      |=> rd_data_q[`FSS_W_PG_N] == $past(pg_n[rd_page])
      && rd_data_q[`FSS_W_OFF] == $past(out_off[rd_page]);
  endproperty
  a_live_read: assert property (p_live_read) else $error("live bits not read back");

  property p_vout_sum;
    vout_ov_evt[0] && !fault_clr[0] |=> sum_w[0][`FSS_W_VOUT] && sum_w[0][`FSS_W_OV];
  endproperty
  a_vout_sum: assert property (p_vout_sum) else $error("ov not summarised");

  property p_oc_sum;
    iout_oc_evt[0] |=> sum_w[0][`FSS_W_IOUT] && sum_w[0][`FSS_W_OC];
  endproperty
  a_oc_sum: assert property (p_oc_sum) else $error("oc not summarised");

  property p_vin_sum;
    vin_uv_evt |=> sum_w[0][`FSS_W_INPUT] && sum_w[0][`FSS_W_VIN_UV];
  endproperty
  a_vin_sum: assert property (p_vin_sum) else $error("vin uv missing");

  property p_pg_off;
    sum_w[0][`FSS_W_PG_N] == pg_n[0] && sum_w[0][`FSS_W_OFF] == out_off[0];
  endproperty
  a_pg_off: assert property (p_pg_off) else $error("live bits wrong");

  property p_other;
    (temp_evt[0] || cml_evt || mfr_evt) |=> sum_w[0][`FSS_W_OTHER];
  endproperty
  a_other: assert property (p_other) else $error("other bit missing");

  property p_busy_hold;
    busy_evt[0] ##1 !fault_clr[0] |=> sum_w[0][`FSS_W_BUSY];
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy not held");

  property p_uv_nota;
    vout_uv_evt[0] |=> vout_st[0][`FSS_V_UV] && sum_w[0][`FSS_W_NOTA];
  endproperty
  a_uv_nota: assert property (p_uv_nota) else $error("uv not reported");

  property p_unused;
    sum_w[0][10] == 1'b0 && sum_w[0][8] == 1'b0 && vout_st[0][6:5] == 2'b00
      && vout_st[0][3:0] == 4'h0;
  endproperty
  a_unused: assert property (p_unused) else $error("unused bit set");

  property p_clr;
    fault_clr[0] && !vout_ov_evt[0] |=> !vout_st[0][`FSS_V_OV];
  endproperty
  a_clr: assert property (p_clr) else $error("clear failed");

  // ****************************************
  // flag to bit mapping
  // ****************************************
  property p_in_warn;
    vin_oth_evt |=> sum_w[0][`FSS_W_INPUT] && sum_w[0][`FSS_W_NOTA];
  endproperty
  a_in_warn: assert property (p_in_warn) else $error("input warning missing");

  property p_mfr_sum;
    mfr_evt |=> sum_w[1][`FSS_W_MFR] && sum_w[1][`FSS_W_NOTA];
  endproperty
  a_mfr_sum: assert property (p_mfr_sum) else $error("mfr bit missing");

  property p_temp_sum;
    temp_evt[0] |=> sum_w[0][`FSS_W_TEMP];
  endproperty
  a_temp_sum: assert property (p_temp_sum) else $error("temperature bit missing");

  property p_cml_sum;
    cml_evt |=> sum_w[1][`FSS_W_CML];
  endproperty
  a_cml_sum: assert property (p_cml_sum) else $error("cml bit missing");

  property p_ov_page1;
    vout_ov_evt[1] |=> vout_st[1][`FSS_V_OV] && sum_w[1][`FSS_W_OV]
      && sum_w[1][`FSS_W_VOUT];
  endproperty
  a_ov_page1: assert property (p_ov_page1) else $error("page 1 ov missing");

  property p_uv_page1;
    vout_uv_evt[1] |=> vout_st[1][`FSS_V_UV] && sum_w[1][`FSS_W_VOUT];
  endproperty
  a_uv_page1: assert property (p_uv_page1) else $error("page 1 uv missing");

  property p_ov_sticky;
    ov_q[0] && !fault_clr[0] |=> ov_q[0];
  endproperty
  a_ov_sticky: assert property (p_ov_sticky) else $error("ov flag dropped");

  property p_oc_cause;
    $rose(sum_w[0][`FSS_W_OC]) |-> $past(iout_oc_evt[0]);
  endproperty
  a_oc_cause: assert property (p_oc_cause) else $error("oc bit without event");

  property p_busy_cause;
    $rose(sum_w[0][`FSS_W_BUSY]) |-> $past(busy_evt[0]);
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy bit without event");

  property p_nota_src;
    sum_w[0][`FSS_W_NOTA] |-> sum_w[0][`FSS_W_VOUT] || sum_w[0][`FSS_W_INPUT]
      || sum_w[0][`FSS_W_MFR];
  endproperty
  a_nota_src: assert property (p_nota_src) else $error("other fault without source");

  property p_unused_p1;
    sum_w[1][10] == 1'b0 && sum_w[1][8] == 1'b0 && vout_st[1][6:5] == 2'b00
      && vout_st[1][3:0] == 4'h0;
  endproperty
  a_unused_p1: assert property (p_unused_p1) else $error("page 1 unused bit set");

  c_word_read: cover property (rd_req && rd_cmd == `FSS_CMD_SUM_WORD ##1 rd_data_q != 16'h0000);
  c_set_clr:   cover property (vout_ov_evt[0] && fault_clr[0]);
  c_bad_cmd:   cover property (rd_err_q);
  c_live_off:  cover property (rd_req && rd_cmd == `FSS_CMD_SUM_WORD && out_off[1]);
  c_glob_p1:   cover property (rd_req && rd_page != '0 && sum_w[1][`FSS_W_INPUT]);

endmodule
`default_nettype wire

// *** hdl/fss_cfg.svh ***
`ifndef FSS_CFG_SVH
`define FSS_CFG_SVH
// command codes of the read-only status registers
`define FSS_CMD_SUM_BYTE  8'h78
`define FSS_CMD_SUM_WORD  8'h79
`define FSS_CMD_VOUT_STAT 8'h7A
// reset values
`define FSS_SUM_RST       16'h0000
`define FSS_VOUT_RST      8'h00
// summary word bit positions
`define FSS_W_VOUT        15
`define FSS_W_IOUT        14
`define FSS_W_INPUT       13
`define FSS_W_MFR         12
`define FSS_W_PG_N        11
`define FSS_W_OTHER       9
`define FSS_W_BUSY        7
`define FSS_W_OFF         6
`define FSS_W_OV          5
`define FSS_W_OC          4
`define FSS_W_VIN_UV      3
`define FSS_W_TEMP        2
`define FSS_W_CML         1
`define FSS_W_NOTA        0
// output-voltage status bit positions
`define FSS_V_OV          7
`define FSS_V_UV          4
`endif

// *** hdl/fss_pkg.sv ***
`default_nettype none
package fss_pkg;
  typedef logic [15:0] fss_word_type;
  typedef logic [7:0]  fss_byte_type;
endpackage
`default_nettype wire

// *** testbench/fss_host_model.sv ***
`default_nettype none
module fss_host_model #(
  parameter int PW = 1
) (
  // clock
  input  wire logic          clk_sys,
  // command read port of the block
  output logic               rd_req,
  output logic [7:0]         rd_cmd,
  output logic [PW-1:0]      rd_page,
  input  wire logic [15:0]   rd_data_q,
  input  wire logic          rd_ack_q,
  input  wire logic          rd_err_q
);
  timeunit 1ns;
  timeprecision 1ns;
  // ***************************************
  // host side: only reads, never writes
  // ***************************************
  // idle bus at time zero
  initial begin
    rd_req  = 1'b0;
    rd_cmd  = 8'h00;
    rd_page = '0;
  end
  // one read: request for one edge, answer taken one edge later
  task automatic rd(input logic [7:0] c, input logic [PW-1:0] p,
                    output logic [15:0] d, output logic a, output logic e);
    @(posedge clk_sys);
    rd_req  <= 1'b1;
    rd_cmd  <= c;
    rd_page <= p;
    @(posedge clk_sys);
    rd_req  <= 1'b0;
    @(posedge clk_sys);
    d = rd_data_q;
    a = rd_ack_q;
    e = rd_err_q;
  endtask
endmodule
`default_nettype wire

// *** testbench/fss_status_regs_tb_top.sv ***
`default_nettype none
module fss_status_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ***************************************
  // stimulus and bookkeeping
  // ***************************************
  logic        clk_sys   = 1'b0;
  logic        rst_n     = 1'b0;
  logic [13:0] ev        = 14'h0000;
  logic [1:0]  pg_n      = 2'h0;
  logic [1:0]  out_off   = 2'h0;
  logic [1:0]  fault_clr = 2'h0;
  logic        rd_req;
  logic [7:0]  rd_cmd;
  logic [0:0]  rd_page;
  logic [15:0] rd_data_q;
  logic        rd_ack_q;
  logic        rd_err_q;
  int          errors      = 0;
  int          check_count = 0;
  // summary word expected after a single event, indexed by event bit
  logic [15:0] exp_w [14] = '{16'h8220, 16'h8220, 16'h8201, 16'h8201, 16'h4210,
                              16'h4210, 16'h0204, 16'h0204, 16'h0080, 16'h0080,
                              16'h2208, 16'h2201, 16'h0202, 16'h1201};
  // free running 25 MHz clock
  always #20 clk_sys = ~clk_sys;
  // ***************************************
  // block and host
  // ***************************************
  fss_status_regs #(.NPAGE(2), .PW(1)) i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n),
    .vout_ov_evt(ev[1:0]), .vout_uv_evt(ev[3:2]), .iout_oc_evt(ev[5:4]),
    .temp_evt(ev[7:6]), .busy_evt(ev[9:8]), .vin_uv_evt(ev[10]),
    .vin_oth_evt(ev[11]), .cml_evt(ev[12]), .mfr_evt(ev[13]),
    .pg_n(pg_n), .out_off(out_off), .fault_clr(fault_clr),
    .rd_req(rd_req), .rd_cmd(rd_cmd), .rd_page(rd_page),
    .rd_data_q(rd_data_q), .rd_ack_q(rd_ack_q), .rd_err_q(rd_err_q));
  fss_host_model #(.PW(1)) i_host (
    .clk_sys(clk_sys), .rd_req(rd_req), .rd_cmd(rd_cmd), .rd_page(rd_page),
    .rd_data_q(rd_data_q), .rd_ack_q(rd_ack_q), .rd_err_q(rd_err_q));
  // ***************************************
  // tasks
  // ***************************************
  // verdict and end of run
  task automatic stop_test();
    if (errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // four-state compare, counts every call
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // read and compare ack, error flag and data
  task automatic rd(logic [7:0] c, logic [0:0] p, logic [15:0] xd, logic xe);
    logic [15:0] d;
    logic        a;
    logic        e;
    i_host.rd(c, p, d, a, e);
    chk("rd_ack_q", 16'h0001, {15'h0000, a});
    chk("rd_err_q", {15'h0000, xe}, {15'h0000, e});
    chk("rd_data_q", xd, d);
  endtask
  // ***************************************
  // tests
  // ***************************************
  // watchdog: the sequence needs well under 1000 cycles
  initial begin
    #200000;
    errors++;
    stop_test();
  end
  // main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      rd(8'h79, p[0:0], 16'h0000, 1'b0);
      rd(8'h7A, p[0:0], 16'h0000, 1'b0);
      rd(8'h78, p[0:0], 16'h0000, 1'b0);
    end
    // live levels on page 1 only; not latched, so they drop again
    pg_n    <= 2'h2;
    out_off <= 2'h2;
    rd(8'h79, 1'b1, 16'h0840, 1'b0);
    rd(8'h79, 1'b0, 16'h0000, 1'b0);
    pg_n    <= 2'h0;
    out_off <= 2'h0;
    rd(8'h79, 1'b1, 16'h0000, 1'b0);
    // each event alone, then cleared, so bits cannot mask one another
    for (int k = 0; k < 14; k++) begin
      @(posedge clk_sys);
      ev <= 14'h0001 << k;
      @(posedge clk_sys);
      ev <= 14'h0000;
      rd(8'h79, k[0:0], exp_w[k], 1'b0);
      rd(8'h78, k[0:0], {8'h00, exp_w[k][7:0]}, 1'b0);
      rd(8'h7A, k[0:0], (k < 2) ? 16'h0080 : (k < 4) ? 16'h0010 : 16'h0000, 1'b0);
      rd(8'h79, ~k[0:0], (k > 9) ? exp_w[k] : 16'h0000, 1'b0);
      @(posedge clk_sys);
      fault_clr <= 2'h3;
      @(posedge clk_sys);
      fault_clr <= 2'h0;
    end
    // event and clear in one cycle: the event is kept
    @(posedge clk_sys);
    ev        <= 14'h0001;
    fault_clr <= 2'h1;
    @(posedge clk_sys);
    ev        <= 14'h0000;
    fault_clr <= 2'h0;
    rd(8'h79, 1'b0, 16'h8220, 1'b0);
    rd(8'h7A, 1'b0, 16'h0080, 1'b0);
    // reset in mid-run drops latched faults back to zero
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(8'h79, 1'b0, 16'h0000, 1'b0);
    rd(8'h7A, 1'b0, 16'h0000, 1'b0);
    // unknown code is refused with zero data
    rd(8'h7B, 1'b0, 16'h0000, 1'b1);
    stop_test();
  end
endmodule
`default_nettype wire
